// [rtl/smbus_arp_pkg.sv]
// Shared constants, types and helper functions of the SMBus ARP slave front end
package smbus_arp_pkg;

  // Address resolution defaults
  localparam logic [6:0] ARP_DEFAULT_ADDR = 7'h61;
  localparam logic [6:0] FIXED_ADDR_BASE  = 7'h50;
  localparam logic [2:0] ARP_LEVEL_MIN    = 3'h4;

  // ARP command codes
  localparam logic [7:0] CMD_PREPARE  = 8'h01;
  localparam logic [7:0] CMD_RESET    = 8'h02;
  localparam logic [7:0] CMD_GET_UDID = 8'h03;
  localparam logic [7:0] CMD_ASSIGN   = 8'h04;

  // Identifier fields; version, vendor and device values are arbitrary
  localparam logic [7:0]  UDID_CAPS    = 8'hc1;
  localparam logic [7:0]  UDID_VERSION = 8'h01;
  localparam logic [15:0] UDID_VENDOR  = 16'h0abc;
  localparam logic [15:0] UDID_DEVICE  = 16'h0def;
  localparam logic [15:0] UDID_IFACE   = 16'h0004;
  localparam logic [15:0] UDID_SUBSYS  = 16'h0000;
  localparam logic [7:0]  UDID_COUNT   = 8'h11;

  // Byte positions inside an ARP transfer
  localparam logic [4:0] IDX_COUNT     = 5'h01;
  localparam logic [4:0] IDX_UDID_LAST = 5'h11;
  localparam logic [4:0] IDX_NEW_ADDR  = 5'h12;
  localparam logic [4:0] IDX_PEC       = 5'h13;
  localparam logic [4:0] IDX_MAX       = 5'h1f;

  localparam logic [7:0]  CRC_POLY   = 8'h07;
  localparam logic [15:0] LFSR_SEED  = 16'hace1;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_SKIP} link_state_e;

  typedef struct packed {
    logic [1:0]  noise_sync;
    logic [15:0] lfsr;
  } rng_state_s;

  localparam rng_state_s RNG_RESET = '{noise_sync: 2'h0, lfsr: LFSR_SEED};

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_prev;
    logic        sda_prev;
    link_state_e state;
    logic [3:0]  bit_count;
    logic [7:0]  rx_shift;
    logic [7:0]  tx_shift;
    logic        sda_oe;
    logic        read_dir;
    logic        arp_target;
    logic        addr_phase;
    logic        in_frame;
    logic        master_ack;
    logic [4:0]  byte_index;
    logic [7:0]  arp_cmd;
    logic        udid_pending;
    logic        udid_mismatch;
    logic [6:0]  new_addr;
    logic [7:0]  crc;
    logic [7:0]  register_pointer;
    logic        block_mode;
    logic        reg_we;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic        strap_done;
    logic        arp_mode;
    logic [2:0]  strap_id_bits;
    logic [15:0] random_id;
    logic [6:0]  slave_addr;
    logic        addr_valid;
    logic        addr_resolved;
  } slave_state_s;

  // CRC-8 with polynomial x^8+x^2+x+1 over one byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

endpackage : smbus_arp_pkg

// [rtl/udid_random_source.sv]
// Free-running LFSR stirred by a noise pin, source of the random identifier part
`timescale 1ns/1ps
module udid_random_source
  import smbus_arp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_noise,
  output logic [15:0]      o_value
);

  rng_state_s r_reg;
  rng_state_s r_next;
  logic       feedback;

  always_comb begin
    r_next = r_reg;
    r_next.noise_sync = {r_reg.noise_sync[0], i_noise};
    feedback = r_reg.lfsr[15] ^ r_reg.lfsr[13] ^ r_reg.lfsr[12] ^ r_reg.lfsr[10]
             ^ r_reg.noise_sync[1] ^ (r_reg.lfsr == 16'h0000);
    r_next.lfsr = {r_reg.lfsr[14:0], feedback};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= RNG_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_value = r_reg.lfsr;

endmodule : udid_random_source

// [rtl/smbus_arp_slave.sv]
// SMBus 2.0 slave front end with address resolution, identifier and register pointer
// Function
// - Strap level is taken once after power-up; later changes are ignored.
// - Levels 7..4 pick ARP-capable mode with id bits 111..100.
// - Levels 3..0 pick fixed mode at address 0x53..0x50.
// - ARP mode serves Prepare, Assign, Reset and Get UDID general and directed.
// - General commands reach all devices; directed need an assigned address.
// - ARP commands are checked by PEC; ARP replies end with PEC.
// - Identifier is 128 bits sent most significant byte first.
// - Identifier bits 127:120 are capabilities 11000001.
// - Identifier bits 79:64 report interface value 0x0004.
// - Subsystem vendor and device fields read zero.
// - Vendor field: zeros, id bits at 18:16, random value at 15:0.
// - The random part comes from an internal generator.
// - Fixed mode supports ARP but Assign Address keeps the strap address.
// - SDA falling while SCL high is a start; byte shifting begins.
// - First byte is seven address bits MSB first plus direction.
// - Matched device pulls SDA low for the ninth clock; others stay idle.
// - Direction 0 is a master write, 1 a master read.
// - Bytes are nine clocks; SDA changes only while SCL low.
// - SDA rising while SCL high is a stop ending the transaction.
// - First write byte is stored in the register pointer.
// - Pointer MSB 0 is single-byte, 1 is block with read length from I_BLOCK_COUNT.
`timescale 1ns/1ps
module smbus_arp_slave
  import smbus_arp_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  output logic             O_SDA,
  output logic             O_SDA_OE,
  input  wire logic [2:0]  I_STRAP_LEVEL,
  input  wire logic        I_STRAP_VALID,
  input  wire logic        I_NOISE,
  input  wire logic [7:0]  I_REG_RDATA,
  input  wire logic [7:0]  I_BLOCK_COUNT,
  output logic [6:0]       O_REG_ADDR,
  output logic [7:0]       O_REG_WDATA,
  output logic             O_REG_WE,
  output logic             O_REG_RD,
  output logic             O_ARP_MODE,
  output logic [6:0]       O_SLAVE_ADDR,
  output logic             O_ADDR_VALID,
  output logic             O_STRAP_DONE
);

  slave_state_s r_reg;
  slave_state_s r_next;
  logic [15:0]  rng_value;
  logic         scl_now;
  logic         sda_now;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic [7:0]   byte_in;
  logic [7:0]   crc_in;
  logic [7:0]   tx_byte;
  logic [127:0] udid;
  logic         ack;
  logic         own_hit;
  logic         arp_hit;

  udid_random_source u_rng (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_noise (I_NOISE),
    .o_value (rng_value)
  );

  function automatic logic [127:0] udid_vec(input logic [2:0] id, input logic [15:0] rnd);
    return {UDID_CAPS, UDID_VERSION, UDID_VENDOR, UDID_DEVICE, UDID_IFACE,
            UDID_SUBSYS, UDID_SUBSYS, 13'h0000, id, rnd};
  endfunction : udid_vec

  // Byte k of the identifier, k = 0 being bits 127:120
  function automatic logic [7:0] udid_byte(input logic [127:0] vec, input logic [3:0] k);
    logic [127:0] s;
    s = vec >> {~k, 3'b000};
    return s[7:0];
  endfunction : udid_byte

  assign scl_now   = r_reg.scl_sync[1];
  assign sda_now   = r_reg.sda_sync[1];
  assign scl_rise  = scl_now & ~r_reg.scl_prev;
  assign scl_fall  = ~scl_now & r_reg.scl_prev;
  assign start_det = scl_now & r_reg.scl_prev & r_reg.sda_prev & ~sda_now;
  assign stop_det  = scl_now & r_reg.scl_prev & ~r_reg.sda_prev & sda_now;
  assign byte_in   = r_reg.rx_shift;
  assign crc_in    = crc8(r_reg.crc, byte_in);
  assign udid      = udid_vec(r_reg.strap_id_bits, r_reg.random_id);

  // Next byte to send on a master read
  always_comb begin
    tx_byte = IDLE_BYTE;
    if (r_reg.arp_target) begin
      if (r_reg.byte_index == 5'h00) begin
        tx_byte = UDID_COUNT;
      end else if (r_reg.byte_index <= 5'h10) begin
        tx_byte = udid_byte(udid, 4'(r_reg.byte_index - 5'h01));
      end else if (r_reg.byte_index == IDX_UDID_LAST) begin
        tx_byte = r_reg.addr_valid ? {r_reg.slave_addr, 1'b1} : IDLE_BYTE;
      end else if (r_reg.byte_index == IDX_NEW_ADDR) begin
        tx_byte = r_reg.crc;
      end
    end else if (r_reg.block_mode && r_reg.byte_index == 5'h00) begin
      tx_byte = I_BLOCK_COUNT;
    end else begin
      tx_byte = I_REG_RDATA;
    end
  end

  always_comb begin
    r_next  = r_reg;
    ack     = 1'b0;
    own_hit = 1'b0;
    arp_hit = 1'b0;
    r_next.reg_we   = 1'b0;
    r_next.reg_rd   = 1'b0;
    r_next.scl_sync = {r_reg.scl_sync[0], I_SCL};
    r_next.sda_sync = {r_reg.sda_sync[0], I_SDA};
    r_next.scl_prev = scl_now;
    r_next.sda_prev = sda_now;

    if (!r_reg.strap_done && I_STRAP_VALID) begin
      r_next.strap_done = 1'b1;
      r_next.random_id  = rng_value;
      if (I_STRAP_LEVEL >= ARP_LEVEL_MIN) begin
        r_next.arp_mode      = 1'b1;
        r_next.strap_id_bits = I_STRAP_LEVEL;
        r_next.addr_valid    = 1'b0;
      end else begin
        r_next.arp_mode   = 1'b0;
        r_next.slave_addr = FIXED_ADDR_BASE | {5'h00, I_STRAP_LEVEL[1:0]};
        r_next.addr_valid = 1'b1;
      end
    end

    unique case (r_reg.state)
      ST_IDLE, ST_SKIP: begin
      end
      ST_RX: begin
        if (scl_rise && r_reg.bit_count < 4'h8) begin
          r_next.rx_shift  = {r_reg.rx_shift[6:0], sda_now};
          r_next.bit_count = r_reg.bit_count + 4'h1;
        end else if (scl_fall && r_reg.bit_count == 4'h8) begin
          r_next.crc = crc_in;
          if (r_reg.addr_phase) begin
            own_hit = r_reg.strap_done && r_reg.addr_valid
                      && byte_in[7:1] == r_reg.slave_addr;
            arp_hit = r_reg.strap_done && byte_in[7:1] == ARP_DEFAULT_ADDR;
            r_next.arp_target = arp_hit && !own_hit;
            r_next.read_dir   = byte_in[0];
            r_next.addr_phase = 1'b0;
            r_next.byte_index = 5'h00;
            r_next.in_frame   = 1'b1;
            ack = own_hit || (arp_hit && (!byte_in[0] || r_reg.udid_pending));
          end else if (r_reg.arp_target) begin
            ack = 1'b1;
            r_next.byte_index = (r_reg.byte_index == IDX_MAX) ? IDX_MAX
                                : r_reg.byte_index + 5'h01;
            if (r_reg.byte_index == 5'h00) begin
              r_next.arp_cmd       = byte_in;
              r_next.udid_mismatch = 1'b0;
              r_next.udid_pending  = 1'b0;
              if (byte_in == CMD_GET_UDID) begin
                ack = !r_reg.addr_resolved;
                r_next.udid_pending = !r_reg.addr_resolved;
              end else if (r_reg.addr_valid && byte_in[7:1] == r_reg.slave_addr) begin
                r_next.udid_pending = byte_in[0];
              end else begin
                ack = byte_in == CMD_PREPARE || byte_in == CMD_RESET
                      || byte_in == CMD_ASSIGN;
              end
            end else if (r_reg.arp_cmd == CMD_ASSIGN) begin
              if (r_reg.byte_index == IDX_COUNT) begin
                r_next.udid_mismatch = byte_in != UDID_COUNT;
              end else if (r_reg.byte_index <= IDX_UDID_LAST) begin
                r_next.udid_mismatch = r_reg.udid_mismatch
                  || byte_in != udid_byte(udid, 4'(r_reg.byte_index - 5'h02));
              end else if (r_reg.byte_index == IDX_NEW_ADDR) begin
                r_next.new_addr = byte_in[7:1];
              end else if (r_reg.byte_index == IDX_PEC) begin
                ack = crc_in == 8'h00 && !r_reg.udid_mismatch;
                if (ack) begin
                  r_next.addr_resolved = 1'b1;
                  if (r_reg.arp_mode) begin
                    r_next.slave_addr = r_reg.new_addr;
                    r_next.addr_valid = 1'b1;
                  end
                end
              end else begin
                ack = 1'b0;
              end
            end else if (r_reg.byte_index == IDX_COUNT && !r_reg.udid_pending) begin
              ack = crc_in == 8'h00;
              if (ack) begin
                r_next.addr_resolved = 1'b0;
                if (r_reg.arp_mode && r_reg.arp_cmd != CMD_PREPARE) begin
                  r_next.addr_valid = 1'b0;
                end
              end
            end else begin
              ack = 1'b0;
            end
          end else begin
            ack = 1'b1;
            r_next.byte_index = (r_reg.byte_index == IDX_MAX) ? IDX_MAX
                                : r_reg.byte_index + 5'h01;
            if (r_reg.byte_index == 5'h00) begin
              r_next.register_pointer = byte_in;
              r_next.block_mode       = byte_in[7];
            end else if (!(r_reg.block_mode && r_reg.byte_index == 5'h01)) begin
              r_next.reg_we    = 1'b1;
              r_next.reg_wdata = byte_in;
              if (r_reg.block_mode && r_reg.byte_index > 5'h02) begin
                r_next.register_pointer = {1'b1, r_reg.register_pointer[6:0] + 7'h01};
              end
            end
          end
          r_next.state  = ack ? ST_ACK : ST_SKIP;
          r_next.sda_oe = ack;
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          r_next.sda_oe    = 1'b0;
          r_next.bit_count = 4'h0;
          r_next.state     = ST_RX;
          if (r_reg.read_dir) begin
            r_next.tx_shift   = tx_byte;
            r_next.sda_oe     = ~tx_byte[7];
            r_next.state      = ST_TX;
            r_next.byte_index = r_reg.byte_index + 5'h01;
            r_next.crc        = crc8(r_reg.crc, tx_byte);
            r_next.reg_rd     = !r_reg.arp_target && !r_reg.block_mode;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (r_reg.bit_count == 4'h7) begin
            r_next.sda_oe = 1'b0;
            r_next.state  = ST_MACK;
          end else begin
            r_next.tx_shift  = {r_reg.tx_shift[6:0], 1'b0};
            r_next.sda_oe    = ~r_reg.tx_shift[6];
            r_next.bit_count = r_reg.bit_count + 4'h1;
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          r_next.master_ack = ~sda_now;
          if (~sda_now && !r_reg.arp_target && r_reg.block_mode
              && r_reg.byte_index >= 5'h02) begin
            r_next.register_pointer = {1'b1, r_reg.register_pointer[6:0] + 7'h01};
          end
        end else if (scl_fall) begin
          if (r_reg.master_ack) begin
            r_next.tx_shift   = tx_byte;
            r_next.sda_oe     = ~tx_byte[7];
            r_next.bit_count  = 4'h0;
            r_next.state      = ST_TX;
            r_next.byte_index = (r_reg.byte_index == IDX_MAX) ? IDX_MAX
                                : r_reg.byte_index + 5'h01;
            r_next.crc        = crc8(r_reg.crc, tx_byte);
            r_next.reg_rd     = !r_reg.arp_target
                                && !(r_reg.block_mode && r_reg.byte_index == 5'h00);
          end else begin
            r_next.state = ST_SKIP;
          end
        end
      end
    endcase

    if (start_det) begin
      r_next.state      = ST_RX;
      r_next.bit_count  = 4'h0;
      r_next.addr_phase = 1'b1;
      r_next.sda_oe     = 1'b0;
      r_next.reg_rd     = 1'b0;
      if (!r_reg.in_frame) begin
        r_next.crc = 8'h00;
      end
    end else if (stop_det) begin
      r_next.state    = ST_IDLE;
      r_next.sda_oe   = 1'b0;
      r_next.in_frame = 1'b0;
      r_next.reg_rd   = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign O_SDA        = 1'b0;
  assign O_SDA_OE     = r_reg.sda_oe;
  assign O_REG_ADDR   = r_reg.register_pointer[6:0];
  assign O_REG_WDATA  = r_reg.reg_wdata;
  assign O_REG_WE     = r_reg.reg_we;
  assign O_REG_RD     = r_reg.reg_rd;
  assign O_ARP_MODE   = r_reg.arp_mode;
  assign O_SLAVE_ADDR = r_reg.slave_addr;
  assign O_ADDR_VALID = r_reg.addr_valid;
  assign O_STRAP_DONE = r_reg.strap_done;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  strap_once_a: assert property ($past(r_reg.strap_done) |->
    $stable(r_reg.arp_mode) && $stable(r_reg.strap_id_bits) && $stable(r_reg.random_id))
    else $error("strap result changed after capture");
  arp_level_a: assert property (!r_reg.strap_done && I_STRAP_VALID
    && I_STRAP_LEVEL >= ARP_LEVEL_MIN |=> r_reg.arp_mode
    && r_reg.strap_id_bits == $past(I_STRAP_LEVEL) && !r_reg.addr_valid)
    else $error("upper strap level did not select ARP mode");
  fixed_addr_a: assert property (!r_reg.strap_done && I_STRAP_VALID
    && I_STRAP_LEVEL < ARP_LEVEL_MIN |=> !r_reg.arp_mode
    && r_reg.slave_addr == 7'h50 + {5'h00, $past(I_STRAP_LEVEL[1:0])})
    else $error("lower strap level gave wrong fixed address");
  udid_fields_a: assert property (udid[127:120] == 8'hc1 && udid[79:64] == 16'h0004
    && udid[63:32] == 32'h0 && udid[31:19] == 13'h0 && udid[18:16] == r_reg.strap_id_bits)
    else $error("identifier fields wrong");
  fixed_keep_a: assert property ($past(r_reg.strap_done) && !r_reg.arp_mode
    |-> $stable(r_reg.slave_addr) && r_reg.addr_valid)
    else $error("fixed mode address changed");
  ack_hold_a: assert property (r_reg.state == ST_RX && scl_fall && r_reg.bit_count == 4'h8
    && ack |=> O_SDA_OE throughout (r_reg.state == ST_ACK)[*2])
    else $error("acknowledge not driven");
  oe_scl_low_a: assert property ($rose(O_SDA_OE) |-> !$past(scl_now))
    else $error("SDA pulled low while SCL high");
  stop_idle_a: assert property (stop_det && !start_det |=> r_reg.state == ST_IDLE
    && !O_SDA_OE && !r_reg.in_frame)
    else $error("stop did not end transaction");
  ptr_load_a: assert property (r_reg.state == ST_RX && scl_fall && r_reg.bit_count == 4'h8
    && !r_reg.addr_phase && !r_reg.arp_target && r_reg.byte_index == 5'h00
    |=> r_reg.register_pointer == $past(byte_in))
    else $error("pointer not loaded from first write byte");
  nomatch_a: assert property (r_reg.state == ST_RX && scl_fall && r_reg.bit_count == 4'h8
    && r_reg.addr_phase && byte_in[7:1] != r_reg.slave_addr
    && byte_in[7:1] != ARP_DEFAULT_ADDR |=> r_reg.state == ST_SKIP && !O_SDA_OE)
    else $error("foreign address acknowledged");
  reset_av_a: assert property ($fell(r_reg.addr_valid) |-> r_reg.arp_mode
    && $past(r_reg.arp_cmd) != CMD_ASSIGN)
    else $error("assigned address lost without reset");

  assign_cover_c: cover property ($rose(r_reg.addr_valid) && r_reg.strap_done);
  udid_read_cover_c: cover property (r_reg.arp_target && r_reg.state == ST_TX
    && r_reg.byte_index == 5'h13);
  block_write_cover_c: cover property (O_REG_WE && r_reg.block_mode);
  reg_read_cover_c: cover property (O_REG_RD && !r_reg.block_mode);

endmodule : smbus_arp_slave

// [bench/smbus_host_model.sv]
// SMBus host controller model: drives SCL and pulls SDA low on the shared bus
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  logic [7:0] pec;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    pec      = 8'h00;
  end

  function automatic logic [7:0] pec_step(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] x;
    x = c ^ v;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction : pec_step

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // Data moves only while SCL is low, sampled late in SCL high
  task automatic bit_x(input logic b, output logic r);
    hold(1);
    scl <= 1'b0;
    hold(5);
    sda_pull <= ~b;
    hold(5);
    scl <= 1'b1;
    hold(10);
    r = sda_in;
  endtask : bit_x

  // A repeated start keeps the running check value
  task automatic start(input logic rep);
    if (!rep) pec = 8'h00;
    hold(1);
    scl <= 1'b0;
    hold(5);
    sda_pull <= 1'b0;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sda_pull <= 1'b1;
    hold(10);
  endtask : start

  task automatic stop();
    hold(1);
    scl <= 1'b0;
    hold(5);
    sda_pull <= 1'b1;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sda_pull <= 1'b0;
    hold(10);
  endtask : stop

  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
    pec = pec_step(pec, v);
  endtask : wr_byte

  task automatic rd_byte(input logic ack_it, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      v[i] = r;
    end
    bit_x(~ack_it, r);
    pec = pec_step(pec, v);
  endtask : rd_byte
endmodule : smbus_host_model

// [bench/testbench.sv]
// Self-checking bench for the SMBus ARP slave front end
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst;
  logic        valid;
  logic        noise;
  logic [2:0]  lvl;
  logic [2:0]  cur;
  logic [7:0]  rdata;
  logic [7:0]  blk;
  logic        scl, pull, oe, sda_o, we, rd, arp, av, done;
  logic [6:0]  ra, sa;
  logic [7:0]  wd, r, p, d;
  logic [7:0]  udid [16];
  logic [14:0] note;
  logic [14:0] exp_q [$];
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          rd_seen = 0;
  int          seed = 49;
  wire         sda = ~((oe & ~sda_o) | pull);

  always #12.5 clk = ~clk;

  smbus_arp_slave DUT (.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o),
    .O_SDA_OE(oe), .I_STRAP_LEVEL(lvl), .I_STRAP_VALID(valid), .I_NOISE(noise),
    .I_REG_RDATA(rdata), .I_BLOCK_COUNT(blk), .O_REG_ADDR(ra), .O_REG_WDATA(wd),
    .O_REG_WE(we), .O_REG_RD(rd), .O_ARP_MODE(arp), .O_SLAVE_ADDR(sa),
    .O_ADDR_VALID(av), .O_STRAP_DONE(done));

  smbus_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_pull(pull));

  // Register file stand-in: read data follows the pointer
  always @(posedge clk) begin
    noise <= 1'($random(seed));
    rdata <= {1'b0, ra} ^ 8'h5a;
    cycles++;
    if (cycles == 50000) begin
      miscompares++;
      report_and_stop();
    end
  end

  always @(posedge clk) begin
    if (rd === 1'b1) begin
      rd_seen++;
    end
    if (we === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK({ra, wd}, note)
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic send(input logic [7:0] b, input logic ea);
    logic ack;
    host.wr_byte(b, ack);
    `CHK(ack, ea)
  endtask : send

  task automatic strap(input logic [2:0] l);
    @(posedge clk);
    rst <= 1'b1;
    lvl <= l;
    cur = l;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    valid <= 1'b1;
    repeat (2) @(posedge clk);
    lvl <= ~l;
    repeat (8) @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    `CHK(done, 1'b1)
    `CHK(arp, l[2])
    `CHK(av, ~l[2])
    if (!l[2]) `CHK(sa, 7'h50 + 7'(l[1:0]))
  endtask : strap

  task automatic wr_reg(input logic [6:0] a, input logic [6:0] ptr);
    d = 8'($random(seed));
    host.start(1'b0);
    send({a, 1'b0}, 1'b1);
    send({1'b0, ptr}, 1'b1);
    exp_q.push_back({ptr, d});
    send(d, 1'b1);
    host.stop();
  endtask : wr_reg

  task automatic arp_cmd(input logic [7:0] c, input logic ok);
    host.start(1'b0);
    send(8'hc2, 1'b1);
    send(c, 1'b1);
    send(ok ? host.pec : ~host.pec, ok);
    host.stop();
  endtask : arp_cmd

  // General form while unresolved, directed form {addr,1} once assigned
  task automatic get_udid(input logic [7:0] cmd, input logic [7:0] addr_exp);
    host.start(1'b0);
    send(8'hc2, 1'b1);
    send(cmd, 1'b1);
    host.start(1'b1);
    send(8'hc3, 1'b1);
    host.rd_byte(1'b1, r);
    `CHK(r, 8'h11)
    for (int i = 0; i < 16; i++) host.rd_byte(1'b1, udid[i]);
    host.rd_byte(1'b1, r);
    `CHK(r, addr_exp)
    p = host.pec;
    host.rd_byte(1'b0, r);
    `CHK(r, p)
    host.stop();
    `CHK(udid[0], 8'b11000001)
    `CHK({udid[6], udid[7]}, 16'h0004)
    `CHK({udid[8], udid[9], udid[10], udid[11]}, 32'h0)
    `CHK({udid[12], udid[13]}, {13'h0, cur[2] ? cur : 3'h0})
  endtask : get_udid

  task automatic assign_addr(input logic [6:0] na);
    host.start(1'b0);
    send(8'hc2, 1'b1);
    send(8'h04, 1'b1);
    send(8'h11, 1'b1);
    for (int i = 0; i < 16; i++) send(udid[i], 1'b1);
    send({na, 1'b0}, 1'b1);
    send(host.pec, 1'b1);
    host.stop();
    @(negedge clk);
  endtask : assign_addr

  initial begin
    rst <= 1'b1;
    valid <= 1'b0;
    blk <= 8'h00;
    for (int i = 0; i < 8; i++) strap(3'(i));
    strap(3'h2);
    wr_reg(7'h52, 7'h05);
    host.start(1'b0);
    // Foreign address kept clear of 0xa4 and 0xc2
    send(8'h80, 1'b0);
    send(8'h07, 1'b0);
    host.stop();
    host.start(1'b0);
    send(8'ha5, 1'b1);
    host.rd_byte(1'b0, r);
    `CHK(r, 8'h05 ^ 8'h5a)
    host.stop();
    blk <= 8'($random(seed));
    host.start(1'b0);
    send(8'ha4, 1'b1);
    send(8'h85, 1'b1);
    send(8'h02, 1'b1);
    d = 8'($random(seed));
    exp_q.push_back({7'h05, d});
    send(d, 1'b1);
    exp_q.push_back({7'h06, ~d});
    send(~d, 1'b1);
    host.start(1'b1);
    send(8'ha5, 1'b1);
    host.rd_byte(1'b1, r);
    `CHK(r, blk)
    host.rd_byte(1'b1, r);
    `CHK(r, 8'h06 ^ 8'h5a)
    host.rd_byte(1'b0, r);
    `CHK(r, 8'h07 ^ 8'h5a)
    host.stop();
    `CHK(rd_seen, 3)
    get_udid(8'h03, 8'ha5);
    assign_addr(7'h30);
    `CHK(sa, 7'h52)
    strap(3'h6);
    arp_cmd(8'h01, 1'b1);
    arp_cmd(8'h02, 1'b1);
    get_udid(8'h03, 8'hff);
    assign_addr(7'h30);
    `CHK(sa, 7'h30)
    `CHK(av, 1'b1)
    wr_reg(7'h30, 7'h11);
    arp_cmd(8'h01, 1'b0);
    get_udid(8'h61, 8'h61);
    arp_cmd(8'h60, 1'b1);
    @(negedge clk);
    `CHK(av, 1'b0)
    host.start(1'b0);
    send(8'h60, 1'b0);
    host.stop();
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule : testbench
